// [rtl/alu_branch_pkg.sv]
// Purpose: shared constants and types for the alu and branch datapath
// Assumes: 16-bit words, 40-bit accumulators
// Notes: opcodes and conditions come from the core's decoder
package alu_branch_pkg;
    localparam int WORD_W = 16;
    localparam int ACC_W = 40;
    localparam int LIT10_W = 10;
    localparam int LIT5_W = 5;
    localparam int SLIT4_W = 4;
    localparam int SHAMT_W = 4;
    localparam int HALF_BIT = 8;       // word half carry taken out of bit 7
    localparam int ACC_WORD_LSB = 16;  // word enters accumulator at bit 16
    localparam int ACC_GUARD_MSB = 31; // bits 39:31 equal when no overflow
    // cycle figures of a branch
    localparam int TAKEN_CYCLES = 4;
    localparam int NOT_TAKEN_CYCLES = 1;
    localparam logic [WORD_W-1:0] WORD_ZERO = 16'h0000;
    localparam logic [ACC_W-1:0] ACC_ZERO = 40'h00_0000_0000;
    localparam logic [ACC_W-1:0] ACC_POS_LIM = 40'h00_7FFF_FFFF;
    localparam logic [ACC_W-1:0] ACC_NEG_LIM = 40'hFF_8000_0000;

    typedef enum logic [3:0] {
        OP_NONE      = 4'h0,
        OP_ADD_REG   = 4'h1,
        OP_ADD_LIT10 = 4'h2,
        OP_ADD_LIT5  = 4'h3,
        OP_SUMC_REG  = 4'h4,
        OP_SUMC_L10  = 4'h5,
        OP_SUMC_L5   = 4'h6,
        OP_AND_REG   = 4'h7,
        OP_AND_LIT10 = 4'h8,
        OP_AND_LIT5  = 4'h9,
        OP_SHR_ONE   = 4'hA,
        OP_SHR_REG   = 4'hB,
        OP_SHR_LIT5  = 4'hC,
        OP_ACC_ADD   = 4'hD,
        OP_JMP_COND  = 4'hE,
        OP_JMP       = 4'hF
    } op_t;

    typedef enum logic [4:0] {
        CND_C   = 5'h00,
        CND_GE  = 5'h01,
        CND_GEU = 5'h02,
        CND_GT  = 5'h03,
        CND_GTU = 5'h04,
        CND_LE  = 5'h05,
        CND_LEU = 5'h06,
        CND_LT  = 5'h07,
        CND_LTU = 5'h08,
        CND_N   = 5'h09,
        CND_NC  = 5'h0A,
        CND_NN  = 5'h0B,
        CND_NWRAP = 5'h0C,
        CND_NZ  = 5'h0D,
        CND_AOVF = 5'h0E,
        CND_BOVF = 5'h0F,
        CND_WRAP = 5'h10,
        CND_ASAT = 5'h11,
        CND_BSAT = 5'h12,
        CND_Z   = 5'h13
    } cond_t;

    // gray along idle -> wait1 -> wait2 -> wait3 -> idle
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_WAIT1 = 2'b01,
        ST_WAIT2 = 2'b11,
        ST_WAIT3 = 2'b10
    } br_state_t;
endpackage

// [rtl/word_adder.sv]
// Purpose: 16-bit adder with carry, half carry and signed wrap out
// Assumes: purely combinational, used by add and add-with-carry
// Notes: half carry is the carry out of bit 7 for word data
`timescale 1ns/100ps
module word_adder
    import alu_branch_pkg::*;
(
    input wire logic [WORD_W-1:0] i_a,
    input wire logic [WORD_W-1:0] i_b,
    input wire logic i_cin,
    output logic [WORD_W-1:0] o_sum,
    output logic o_carry,
    output logic o_half,
    output logic o_wrap
);
    logic [WORD_W:0] full;
    logic [HALF_BIT:0] low;

    // low half sum gives the half carry without a second carry chain tap
    always_comb begin
        full = {1'b0, i_a} + {1'b0, i_b} + {{WORD_W{1'b0}}, i_cin};
        low = {1'b0, i_a[HALF_BIT-1:0]} + {1'b0, i_b[HALF_BIT-1:0]}
            + {{HALF_BIT{1'b0}}, i_cin};
        o_sum = full[WORD_W-1:0];
        o_carry = full[WORD_W];
        o_half = low[HALF_BIT];
        // like signs in, unlike sign out
        o_wrap = (i_a[WORD_W-1] == i_b[WORD_W-1]) && (o_sum[WORD_W-1] != i_a[WORD_W-1]);
    end
endmodule

// [rtl/alu_branch_subset.sv]
// Purpose: add, add-with-carry, and, shifts, accumulator add and branches
// Assumes: decoder holds i_op_valid until accepted (o_busy_reg low)
// Notes: results leave on o_result_reg; the decoder writes the target
`timescale 1ns/100ps
module alu_branch_subset
    import alu_branch_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_op_valid,
    input wire logic [3:0] i_op,
    input wire logic [4:0] i_cond,
    input wire logic [WORD_W-1:0] i_a,
    input wire logic [WORD_W-1:0] i_b,
    input wire logic [LIT10_W-1:0] i_lit,
    input wire logic i_acc_sel_b,
    input wire logic i_sat_enable,
    input wire logic i_sticky_clear,
    input wire logic [WORD_W-1:0] i_branch_target,
    output logic o_busy_reg,
    output logic o_done_reg,
    output logic o_result_valid_reg,
    output logic [WORD_W-1:0] o_result_reg,
    output logic o_pc_load_reg,
    output logic [WORD_W-1:0] o_pc_target_reg,
    output logic o_carry_flag,
    output logic o_half_carry_flag,
    output logic o_negative_flag,
    output logic o_signed_wrap_flag,
    output logic o_zero_flag,
    output logic o_accum_a_overflow_flag,
    output logic o_accum_b_overflow_flag,
    output logic o_accum_a_sticky_limit_flag,
    output logic o_accum_b_sticky_limit_flag,
    output logic [ACC_W-1:0] o_accum_a_reg,
    output logic [ACC_W-1:0] o_accum_b_reg
);
    localparam int WAIT_CYCLES = TAKEN_CYCLES - NOT_TAKEN_CYCLES;

    op_t op;
    br_state_t state_reg;
    logic accept, is_branch, br_taken;
    logic [WORD_W-1:0] add_b, sum, shifted, and_res;
    logic add_cin, add_c, add_h, add_v;
    logic is_add, is_and, is_shr_one, is_shr_multi;
    logic [ACC_W-1:0] acc_cur, acc_term, acc_sum, acc_next;
    logic acc_ovf, acc_sat;

    function automatic logic cond_true(input logic [4:0] cc, input logic c, input logic n,
                                       input logic v, input logic z, input logic aov,
                                       input logic bov, input logic asat, input logic bsat);
        case (cc)
            CND_C: cond_true = c;
            CND_GE: cond_true = (n == v);
            CND_GEU: cond_true = c;
            CND_GT: cond_true = !z && (n == v);
            CND_GTU: cond_true = c && !z;
            CND_LE: cond_true = z || (n != v);
            CND_LEU: cond_true = !c || z;
            CND_LT: cond_true = (n != v);
            CND_LTU: cond_true = !c;
            CND_N: cond_true = n;
            CND_NC: cond_true = !c;
            CND_NN: cond_true = !n;
            CND_NWRAP: cond_true = !v;
            CND_NZ: cond_true = !z;
            CND_AOVF: cond_true = aov;
            CND_BOVF: cond_true = bov;
            CND_WRAP: cond_true = v;
            CND_ASAT: cond_true = asat;
            CND_BSAT: cond_true = bsat;
            CND_Z: cond_true = z;
            default: cond_true = 1'b0; // unused codes never branch
        endcase
    endfunction

    function automatic logic [WORD_W-1:0] shr_signed(input logic [WORD_W-1:0] w,
                                                     input logic [LIT5_W-1:0] n);
        shr_signed = WORD_W'($signed(w) >>> n);
    endfunction

    // decode; a new op is only taken while no taken branch is draining
    always_comb begin
        op = op_t'(i_op);
        accept = i_op_valid && (state_reg == ST_IDLE);
        is_branch = (op == OP_JMP) || (op == OP_JMP_COND);
        br_taken = (op == OP_JMP) || cond_true(i_cond, o_carry_flag, o_negative_flag,
            o_signed_wrap_flag, o_zero_flag, o_accum_a_overflow_flag,
            o_accum_b_overflow_flag, o_accum_a_sticky_limit_flag,
            o_accum_b_sticky_limit_flag);
        is_add = (op >= OP_ADD_REG) && (op <= OP_SUMC_L5);
        is_and = (op >= OP_AND_REG) && (op <= OP_AND_LIT5);
        is_shr_one = (op == OP_SHR_ONE);
        is_shr_multi = (op == OP_SHR_REG) || (op == OP_SHR_LIT5);
        add_cin = (op >= OP_SUMC_REG) && o_carry_flag;
        case (op)
            OP_ADD_LIT10, OP_SUMC_L10, OP_AND_LIT10: add_b = {6'h00, i_lit};
            OP_ADD_LIT5, OP_SUMC_L5, OP_AND_LIT5: add_b = {11'h000, i_lit[LIT5_W-1:0]};
            default: add_b = i_b;
        endcase
        and_res = i_a & add_b;
        if (op == OP_SHR_REG) begin
            shifted = shr_signed(i_a, {1'b0, i_b[SHAMT_W-1:0]});
        end else if (op == OP_SHR_LIT5) begin
            shifted = shr_signed(i_a, i_lit[LIT5_W-1:0]);
        end else begin
            shifted = shr_signed(i_a, 5'h01);
        end
    end

    word_adder u_adder (
        .i_a(i_a),
        .i_b(add_b),
        .i_cin(add_cin),
        .o_sum(sum),
        .o_carry(add_c),
        .o_half(add_h),
        .o_wrap(add_v)
    );

    // accumulator add: word at bits 31:16, shifted right by a positive literal
    always_comb begin
        acc_cur = i_acc_sel_b ? o_accum_b_reg : o_accum_a_reg;
        acc_term = {{(ACC_W-WORD_W-ACC_WORD_LSB){i_b[WORD_W-1]}}, i_b, WORD_ZERO};
        if (i_lit[SLIT4_W-1]) begin
            acc_term = acc_term << (5'h10 - {1'b0, i_lit[SLIT4_W-1:0]});
        end else begin
            acc_term = ACC_W'($signed(acc_term) >>> i_lit[SLIT4_W-1:0]);
        end
        acc_sum = acc_cur + acc_term;
        acc_ovf = !((&acc_sum[ACC_W-1:ACC_GUARD_MSB]) || !(|acc_sum[ACC_W-1:ACC_GUARD_MSB]));
        // saturate to the 32-bit range; sticky flag records it
        acc_sat = i_sat_enable && acc_ovf;
        acc_next = acc_sat ? (acc_sum[ACC_W-1] ? ACC_NEG_LIM : ACC_POS_LIM) : acc_sum;
    end

    // branch sequencer: three extra cycles for a taken branch
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            state_reg <= ST_IDLE;
        end else begin
            unique case (state_reg)
                ST_IDLE: if (accept && is_branch && br_taken) state_reg <= ST_WAIT1;
                ST_WAIT1: state_reg <= ST_WAIT2;
                ST_WAIT2: state_reg <= ST_WAIT3;
                ST_WAIT3: state_reg <= ST_IDLE;
            endcase
        end
    end

    // handshake outputs
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_busy_reg <= 1'b0;
            o_done_reg <= 1'b0;
            o_pc_load_reg <= 1'b0;
            o_pc_target_reg <= WORD_ZERO;
        end else begin
            o_busy_reg <= (accept && is_branch && br_taken) || (state_reg == ST_WAIT1)
                || (state_reg == ST_WAIT2);
            o_done_reg <= (accept && !(is_branch && br_taken)) || (state_reg == ST_WAIT3);
            o_pc_load_reg <= (state_reg == ST_WAIT3);
            if (accept && is_branch) o_pc_target_reg <= i_branch_target;
        end
    end

    // word result; latency one cycle for every alu form
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_result_valid_reg <= 1'b0;
            o_result_reg <= WORD_ZERO;
        end else begin
            o_result_valid_reg <= accept && (is_add || is_and || is_shr_one || is_shr_multi);
            if (accept && is_add) o_result_reg <= sum;
            if (accept && is_and) o_result_reg <= and_res;
            if (accept && (is_shr_one || is_shr_multi)) o_result_reg <= shifted;
        end
    end

    // mcu flags; branches and accumulator ops leave them alone
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_carry_flag <= 1'b0;
            o_half_carry_flag <= 1'b0;
            o_negative_flag <= 1'b0;
            o_signed_wrap_flag <= 1'b0;
            o_zero_flag <= 1'b0;
        end else if (accept) begin
            if (is_add) begin
                o_carry_flag <= add_c;
                o_half_carry_flag <= add_h;
                o_signed_wrap_flag <= add_v;
                o_negative_flag <= sum[WORD_W-1];
                o_zero_flag <= (sum == WORD_ZERO);
            end else if (is_and) begin
                o_negative_flag <= and_res[WORD_W-1];
                o_zero_flag <= (and_res == WORD_ZERO);
            end else if (is_shr_one) begin
                o_carry_flag <= i_a[0];
                o_signed_wrap_flag <= 1'b0; // sign kept, so no wrap
                o_negative_flag <= shifted[WORD_W-1];
                o_zero_flag <= (shifted == WORD_ZERO);
            end else if (is_shr_multi) begin
                o_negative_flag <= shifted[WORD_W-1];
                o_zero_flag <= (shifted == WORD_ZERO);
            end
        end
    end

    // accumulators; sticky set beats a clear in the same cycle
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_accum_a_reg <= ACC_ZERO;
            o_accum_b_reg <= ACC_ZERO;
            o_accum_a_overflow_flag <= 1'b0;
            o_accum_b_overflow_flag <= 1'b0;
            o_accum_a_sticky_limit_flag <= 1'b0;
            o_accum_b_sticky_limit_flag <= 1'b0;
        end else begin
            if (i_sticky_clear) begin
                o_accum_a_sticky_limit_flag <= 1'b0;
                o_accum_b_sticky_limit_flag <= 1'b0;
            end
            if (accept && op == OP_ACC_ADD && !i_acc_sel_b) begin
                o_accum_a_reg <= acc_next;
                o_accum_a_overflow_flag <= acc_ovf && !acc_sat;
                if (acc_sat) o_accum_a_sticky_limit_flag <= 1'b1;
            end
            if (accept && op == OP_ACC_ADD && i_acc_sel_b) begin
                o_accum_b_reg <= acc_next;
                o_accum_b_overflow_flag <= acc_ovf && !acc_sat;
                if (acc_sat) o_accum_b_sticky_limit_flag <= 1'b1;
            end
        end
    end

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);

    a_acc_add_mcu_flags: assert property (accept && op == OP_ACC_ADD |=>
        $stable({o_carry_flag, o_half_carry_flag, o_negative_flag, o_signed_wrap_flag, o_zero_flag}))
        else $error("acc add changed mcu flags");
    a_sumc_reg_sum: assert property (accept && op == OP_SUMC_REG |=>
        o_result_reg == WORD_W'($past(i_a) + $past(i_b) + {15'h0000, $past(o_carry_flag)}))
        else $error("carry sum of registers wrong");
    a_sumc_lit10_sum: assert property (accept && op == OP_SUMC_L10 |=>
        o_result_reg == WORD_W'($past(i_a) + {6'h00, $past(i_lit)} + {15'h0000, $past(o_carry_flag)}))
        else $error("carry sum with 10-bit literal wrong");
    a_sumc_lit5_sum: assert property (accept && op == OP_SUMC_L5 |=>
        o_result_valid_reg && o_result_reg == WORD_W'($past(i_a)
        + {11'h000, $past(i_lit[LIT5_W-1:0])} + {15'h0000, $past(o_carry_flag)}))
        else $error("carry sum with 5-bit literal wrong");
    a_shr_one_sign: assert property (accept && is_shr_one |=>
        o_result_reg[WORD_W-1] == $past(i_a[WORD_W-1]) && o_carry_flag == $past(i_a[0]))
        else $error("single shift lost sign or carry");
    a_shr_reg_keeps_cv: assert property (accept && op == OP_SHR_REG |=>
        $stable(o_carry_flag) && $stable(o_signed_wrap_flag))
        else $error("shift by register touched C or wrap");
    a_shr_lit_value: assert property (accept && op == OP_SHR_LIT5 |=>
        o_result_reg == WORD_W'($signed($past(i_a)) >>> $past(i_lit[LIT5_W-1:0])))
        else $error("shift by literal wrong");
    // busy stands on cycles 1..3, retire and pc load come on cycle 4
    a_taken_four_cycles: assert property (accept && is_branch && br_taken |=>
        o_busy_reg[*3] ##1 (o_done_reg && o_pc_load_reg && !o_busy_reg))
        else $error("taken branch not four cycles");
    a_not_taken_one: assert property (accept && is_branch && !br_taken |=>
        o_done_reg && !o_busy_reg && !o_pc_load_reg)
        else $error("untaken branch not one cycle");
    a_carry_branch: assert property (accept && op == OP_JMP_COND && i_cond == CND_C
        && !o_carry_flag |=> !o_busy_reg)
        else $error("carry branch taken with carry clear");
    a_branch_no_flags: assert property (accept && is_branch |=>
        $stable({o_carry_flag, o_half_carry_flag, o_negative_flag, o_signed_wrap_flag, o_zero_flag,
        o_accum_a_overflow_flag, o_accum_b_overflow_flag}))
        else $error("branch changed a flag");
    a_sticky_holds: assert property (o_accum_a_sticky_limit_flag && !i_sticky_clear
        |=> o_accum_a_sticky_limit_flag)
        else $error("sticky flag dropped");
    a_add_carry_out: assert property (accept && op == OP_ADD_REG |=>
        o_carry_flag == $past(17'({1'b0, i_a} + {1'b0, i_b}) >> WORD_W))
        else $error("add carry wrong");
    a_and_flags: assert property (accept && is_and |=>
        $stable(o_carry_flag) && $stable(o_half_carry_flag) && $stable(o_signed_wrap_flag)
        && o_negative_flag == o_result_reg[WORD_W-1] && o_zero_flag == (o_result_reg == WORD_ZERO))
        else $error("and result or flags wrong");
    a_jump_target: assert property (accept && op == OP_JMP |=>
        ##3 (o_pc_load_reg && o_pc_target_reg == $past(i_branch_target, 4)))
        else $error("jump target not loaded");

    c_taken: cover property (accept && is_branch && br_taken);
    c_untaken: cover property (accept && is_branch && !br_taken);
    c_acc_sat: cover property (accept && op == OP_ACC_ADD && acc_sat);
    c_sumc_carry: cover property (accept && op == OP_SUMC_REG && o_carry_flag);
endmodule

// [tb/tb_alu_branch_subset.sv]
// Purpose: self-checking bench for the alu and branch datapath
// Assumes: ops are presented one at a time, valid dropped after the accept edge
// Notes: expected flags are tracked in bench variables, never read back first
`timescale 1ns/100ps
module tb_alu_branch_subset;
    import alu_branch_pkg::*;
    logic i_clock = 1'b0;
    logic i_rst = 1'b1;
    logic i_op_valid = 1'b0;
    logic [3:0] i_op = OP_NONE;
    logic [4:0] i_cond = 5'h00;
    logic [WORD_W-1:0] i_a = 16'h0000;
    logic [WORD_W-1:0] i_b = 16'h0000;
    logic [LIT10_W-1:0] i_lit = 10'h000;
    logic i_acc_sel_b = 1'b0;
    logic i_sat_enable = 1'b0;
    logic i_sticky_clear = 1'b0;
    logic [WORD_W-1:0] i_branch_target = 16'h0000;
    logic o_busy_reg, o_done_reg, o_result_valid_reg, o_pc_load_reg;
    logic [WORD_W-1:0] o_result_reg, o_pc_target_reg;
    logic o_carry_flag, o_half_carry_flag, o_negative_flag, o_signed_wrap_flag, o_zero_flag;
    logic o_accum_a_overflow_flag, o_accum_b_overflow_flag;
    logic o_accum_a_sticky_limit_flag, o_accum_b_sticky_limit_flag;
    logic [ACC_W-1:0] o_accum_a_reg, o_accum_b_reg;
    logic [4:0] flags;
    logic [3:0] accf;
    logic [4:0] ef = 5'h00;
    logic [3:0] eacc = 4'h0;
    int n_mismatch = 0;
    int checked = 0;

    // packed views: {carry, half, negative, wrap, zero} and {a ovf, b ovf, a sticky, b sticky}
    assign flags = {o_carry_flag, o_half_carry_flag, o_negative_flag, o_signed_wrap_flag, o_zero_flag};
    assign accf = {o_accum_a_overflow_flag, o_accum_b_overflow_flag,
                   o_accum_a_sticky_limit_flag, o_accum_b_sticky_limit_flag};

    alu_branch_subset dut (.i_clock(i_clock), .i_rst(i_rst), .i_op_valid(i_op_valid), .i_op(i_op),
        .i_cond(i_cond), .i_a(i_a), .i_b(i_b), .i_lit(i_lit), .i_acc_sel_b(i_acc_sel_b),
        .i_sat_enable(i_sat_enable), .i_sticky_clear(i_sticky_clear), .i_branch_target(i_branch_target),
        .o_busy_reg(o_busy_reg), .o_done_reg(o_done_reg), .o_result_valid_reg(o_result_valid_reg),
        .o_result_reg(o_result_reg), .o_pc_load_reg(o_pc_load_reg), .o_pc_target_reg(o_pc_target_reg),
        .o_carry_flag(o_carry_flag), .o_half_carry_flag(o_half_carry_flag),
        .o_negative_flag(o_negative_flag), .o_signed_wrap_flag(o_signed_wrap_flag),
        .o_zero_flag(o_zero_flag), .o_accum_a_overflow_flag(o_accum_a_overflow_flag),
        .o_accum_b_overflow_flag(o_accum_b_overflow_flag),
        .o_accum_a_sticky_limit_flag(o_accum_a_sticky_limit_flag),
        .o_accum_b_sticky_limit_flag(o_accum_b_sticky_limit_flag),
        .o_accum_a_reg(o_accum_a_reg), .o_accum_b_reg(o_accum_b_reg));

    // 200 mhz clock
    initial begin
        forever #2.5 i_clock = ~i_clock;
    end

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [39:0] exp, input logic [39:0] got);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // called in the time step of a rising edge, so inputs move by nba on it
    task automatic drive(input op_t op, input logic [15:0] a, input logic [15:0] b, input logic [9:0] lit);
        i_op_valid <= 1'b1;
        i_op <= op;
        i_a <= a;
        i_b <= b;
        i_lit <= lit;
    endtask

    // one alu op: result and flags must stand right after the accept edge
    task automatic alu(input op_t op, input logic [15:0] a, input logic [15:0] b, input logic [9:0] lit,
                       input logic [15:0] res, input logic [4:0] fl);
        @(posedge i_clock);
        drive(op, a, b, lit);
        @(posedge i_clock);
        i_op_valid <= 1'b0;
        #1;
        chk("done", 1'b1, o_done_reg);
        chk("result_valid", 1'b1, o_result_valid_reg);
        chk("result", res, o_result_reg);
        chk("flags", fl, flags);
        chk("acc_flags", eacc, accf);
        ef = fl;
    endtask

    // accumulator add; word lands at bit 16, signed sl shifts it right, negative means left
    task automatic acc(input logic sel_b, input logic sat, input logic [15:0] w, input logic [39:0] exp,
                       input logic [3:0] af, input logic [3:0] sl);
        @(posedge i_clock);
        drive(OP_ACC_ADD, 16'h0000, w, {6'h00, sl});
        i_acc_sel_b <= sel_b;
        i_sat_enable <= sat;
        @(posedge i_clock);
        i_op_valid <= 1'b0;
        #1;
        chk("acc_done", 1'b1, o_done_reg);
        chk("acc_no_result", 1'b0, o_result_valid_reg);
        chk("accum", exp, sel_b ? o_accum_b_reg : o_accum_a_reg);
        chk("acc_flags", af, accf);
        chk("flags_kept", ef, flags);
        eacc = af;
    endtask

    // condition outcome per code index, from the bench's own flag copy
    function automatic logic [19:0] want();
        logic c, n, v, z;
        {c, n, v, z} = {ef[4], ef[2], ef[1], ef[0]};
        want = {z, eacc[0], eacc[1], v, eacc[2], eacc[3], ~z, ~v, ~n, ~c, n, ~c, n ^ v, ~c | z,
                z | (n ^ v), c & ~z, ~z & ~(n ^ v), c, ~(n ^ v), c};
    endfunction

    // taken: busy over cycles 1..3, done with pc load on cycle 4; untaken: done on cycle 1
    task automatic br(input op_t op, input logic [4:0] k, input logic tk);
        logic [15:0] tgt;
        tgt = 16'hA5A0 ^ {11'h000, k};
        @(posedge i_clock);
        drive(op, 16'h0000, 16'h0000, 10'h000);
        i_cond <= k;
        i_branch_target <= tgt;
        @(posedge i_clock);
        i_op_valid <= 1'b0;
        #1;
        chk("busy", tk, o_busy_reg);
        if (tk) begin
            chk("pc_target", tgt, o_pc_target_reg);
            repeat (2) @(posedge i_clock);
            #1;
            chk("busy_c3", 1'b1, o_busy_reg);
            @(posedge i_clock);
            #1;
            chk("busy_c4", 1'b0, o_busy_reg);
        end
        chk("br_done", 1'b1, o_done_reg);
        chk("pc_load", tk, o_pc_load_reg);
        chk("br_flags", ef, flags);
        chk("br_acc_flags", eacc, accf);
    endtask

    task automatic s_reset;
        chk("reset_flags", 5'h00, flags);
        chk("reset_acc_flags", 4'h0, accf);
        chk("reset_acc_a", ACC_ZERO, o_accum_a_reg);
        chk("reset_busy", 1'b0, o_busy_reg);
    endtask

    task automatic s_add;
        alu(OP_ADD_REG, 16'h7FFF, 16'h0001, 10'h000, 16'h8000, 5'h0E);
        alu(OP_ADD_LIT10, 16'hFFFF, 16'h0000, 10'h001, 16'h0000, 5'h19);
        alu(OP_ADD_LIT5, 16'h0010, 16'h0000, 10'h3FF, 16'h002F, 5'h00);
    endtask

    task automatic s_sum_with_carry_instruction;
        alu(OP_ADD_REG, 16'hFFFF, 16'h0001, 10'h000, 16'h0000, 5'h19);
        alu(OP_SUMC_REG, 16'h0001, 16'h0002, 10'h000, 16'h0004, 5'h00);
        alu(OP_SUMC_L10, 16'h00FF, 16'h0000, 10'h001, 16'h0100, 5'h08);
    endtask

    // second op accepted on the edge right after the first, sees the fresh carry
    task automatic s_back;
        @(posedge i_clock);
        drive(OP_ADD_REG, 16'hFFFF, 16'h0001, 10'h000);
        @(posedge i_clock);
        drive(OP_SUMC_L5, 16'h7FFF, 16'h0000, 10'h000);
        #1;
        chk("b2b_first", 16'h0000, o_result_reg);
        @(posedge i_clock);
        i_op_valid <= 1'b0;
        #1;
        chk("b2b_second", 16'h8000, o_result_reg);
        chk("b2b_flags", 5'h0E, flags);
        ef = 5'h0E;
    endtask

    task automatic s_and;
        alu(OP_ADD_REG, 16'h8000, 16'h8000, 10'h000, 16'h0000, 5'h13);
        alu(OP_AND_REG, 16'hF0F0, 16'h8F00, 10'h000, 16'h8000, 5'h16);
        alu(OP_AND_LIT10, 16'h00FF, 16'h0000, 10'h300, 16'h0000, 5'h13);
        alu(OP_AND_LIT5, 16'hFFFF, 16'h0000, 10'h3FF, 16'h001F, 5'h12);
    endtask

    // carry left at 1 by the single shift must survive the multi-bit shifts
    task automatic s_shr;
        alu(OP_SHR_ONE, 16'h8001, 16'h0000, 10'h000, 16'hC000, 5'h14);
        alu(OP_SHR_REG, 16'h8000, 16'h0014, 10'h000, 16'hF800, 5'h14);
        alu(OP_SHR_LIT5, 16'h4000, 16'h0000, 10'h00F, 16'h0000, 5'h11);
    endtask

    // last call: minus one shifted left by one, no overflow, sticky stays
    task automatic s_acc;
        acc(1'b0, 1'b0, 16'h4000, 40'h00_4000_0000, 4'h0, 4'h0);
        acc(1'b0, 1'b0, 16'h4000, 40'h00_8000_0000, 4'h8, 4'h0);
        acc(1'b1, 1'b1, 16'h7FFF, 40'h00_7FFF_0000, 4'h8, 4'h0);
        acc(1'b1, 1'b1, 16'h7FFF, ACC_POS_LIM, 4'h9, 4'h0);
        acc(1'b1, 1'b1, 16'hFFFF, 40'h00_7FFD_FFFF, 4'h9, 4'hF);
    endtask

    task automatic s_branches;
        logic [19:0] t;
        t = want();
        for (int k = 0; k < 20; k++) begin
            br(OP_JMP_COND, 5'(k), t[k]);
        end
    endtask

    task automatic s_sticky;
        @(posedge i_clock);
        i_sticky_clear <= 1'b1;
        @(posedge i_clock);
        i_sticky_clear <= 1'b0;
        #1;
        chk("sticky_clear", 4'h8, accf);
        eacc = 4'h8;
    endtask

    initial begin
        repeat (16) @(posedge i_clock);
        i_rst <= 1'b0;
        #1;
        s_reset();
        s_add();
        s_sum_with_carry_instruction();
        s_back();
        s_and();
        s_shr();
        s_acc();
        alu(OP_ADD_REG, 16'h7FFF, 16'h0001, 10'h000, 16'h8000, 5'h0E);
        s_branches();
        s_sticky();
        alu(OP_ADD_REG, 16'hFFFF, 16'h0001, 10'h000, 16'h0000, 5'h19);
        s_branches();
        br(OP_JMP, 5'h00, 1'b1);
        end_of_test();
    end

    // whole run is a few hundred cycles; this bound only cuts a hang
    initial begin
        #20000;
        n_mismatch++;
        end_of_test();
    end
endmodule
